// ### include/mbpwm_consts.svh
`ifndef MBPWM_CONSTS_SVH
`define MBPWM_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MBPWM_ADDR_W          8
`define MBPWM_OFS_IRQ_STATUS  8'h00
`define MBPWM_OFS_IRQ_MASK    8'h04
`define MBPWM_OFS_TIMER_CTRL  8'h08
`define MBPWM_OFS_COUNT_MODE  8'h0C
`define MBPWM_OFS_TIMER_COUNT 8'h10
`define MBPWM_OFS_PRESCALE    8'h14
`define MBPWM_OFS_PRESC_COUNT 8'h18
`define MBPWM_OFS_MATCH_CTRL  8'h1C
`define MBPWM_OFS_MATCH_BASE  8'h20
`define MBPWM_OFS_RELEASE     8'h3C
`define MBPWM_OFS_CAPT_CTRL   8'h40
`define MBPWM_OFS_CAPTURE0    8'h44
`define MBPWM_OFS_CAPTURE1    8'h48
`define MBPWM_OFS_PWM_CTRL    8'h4C
`define MBPWM_OFS_EXT_CTRL    8'h50

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MBPWM_CTRL_EN_BIT     0
`define MBPWM_CTRL_CRST_BIT   1
`define MBPWM_CTRL_PWM_BIT    3
`define MBPWM_MODE_SRC_BIT    2
`define MBPWM_MCTRL_STRIDE    3
`define MBPWM_CCTRL_STRIDE    3
`define MBPWM_PWM_OE_BASE     8
`define MBPWM_MATCH_IRQ_BASE  0
`define MBPWM_CAPT_IRQ_BASE   7

// ----------------------------------------------------------------
// Counts and reset values
// ----------------------------------------------------------------
`define MBPWM_NUM_MATCH       7
`define MBPWM_NUM_CAPT        2
`define MBPWM_NUM_EXT         4
`define MBPWM_NUM_PWM         6
`define MBPWM_NUM_IRQ         9
`define MBPWM_RST_WORD        32'h0000_0000
`define MBPWM_RESP_OKAY       2'h0
`define MBPWM_RESP_SLVERR     2'h2

`endif

// ### include/mbpwm_pkg.sv
package mbpwm_pkg;

   typedef logic [1:0] mbpwm_resp_t;

   // Source of the counting clock
   typedef enum logic [1:0] {
      MBPWM_CNT_TIMER,
      MBPWM_CNT_RISE,
      MBPWM_CNT_FALL,
      MBPWM_CNT_BOTH
   } mbpwm_cnt_mode_t;

   // Action of an external match output
   typedef enum logic [1:0] {
      MBPWM_EXT_KEEP,
      MBPWM_EXT_LOW,
      MBPWM_EXT_HIGH,
      MBPWM_EXT_TOGGLE
   } mbpwm_ext_act_t;

endpackage : mbpwm_pkg

// ### src/mbpwm_top.sv
// Summary of operation
// RL1: A 32-bit counter advances through a programmable 32-bit prescaler.
// RL2: The counter counts clock cycles or edges of a chosen capture input.
// RL3: A capture input edge copies the counter value, optionally with irq.
// RL4: Each match may continue, stop or reset the counter, with opt. irq.
// RL5: Four external outputs go low, high, toggle or hold on their match.
// RL6: Seven match registers give six single or three double edge outputs.
// RL7: Match zero resets the counter and sets one shared pulse period.
// RL8: A single edge output falls at its own match register value.
// RL9: A single edge output rises at every period match unless held low.
// RL10: A double edge output rises and falls at two dedicated matches.
// RL11: Rise before fall gives a positive pulse, otherwise a negative one.
// RL12: Both edges of a double edge output may sit at any count.
// RL13: Period and width are any whole number of counts.
// RL14: In pulse mode, new match values act only once software releases them.
// RL15: With pulse mode off the block is a plain timer with match/capture.
// RL16: The prescale counter wraps at its limit and advances the counter.
// RL17: Released match values load at the period match.
`timescale 1ns/1ns
`default_nettype none
`include "mbpwm_consts.svh"

module mbpwm_top (
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output mbpwm_pkg::mbpwm_resp_t    s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output mbpwm_pkg::mbpwm_resp_t    s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic [1:0]           cap_in,
   output logic [3:0]                match_out,
   output logic [6:1]                pwm_out,
   output logic                      irq
);
   import mbpwm_pkg::*;

   // ----------------------------------------------------------------
   // Reset synchroniser
   // ----------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write and read channels
   // ----------------------------------------------------------------
   logic        awready_reg, wready_reg, bvalid_reg, aw_done_reg;
   logic        w_done_reg, arready_reg, rvalid_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] wd_reg, rdata_reg, rd_word;
   logic [3:0]  ws_reg;
   logic [1:0]  bresp_reg, rresp_reg;
   logic        rd_hit;
   logic        wr_hit;

   wire aw_hs   = s_axi_awvalid && awready_reg;
   wire w_hs    = s_axi_wvalid && wready_reg;
   wire wr_fire = aw_done_reg && w_done_reg && !bvalid_reg;
   wire b_hs    = bvalid_reg && s_axi_bready;
   wire ar_hs   = s_axi_arvalid && arready_reg;
   wire r_hs    = rvalid_reg && s_axi_rready;

   // Ready drops after each handshake so one write is held at a time
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         aw_done_reg <= 1'b0;
         w_done_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `MBPWM_RESP_OKAY;
         aw_addr_reg <= 8'h00;
         wd_reg      <= `MBPWM_RST_WORD;
         ws_reg      <= 4'h0;
      end else begin
         awready_reg <= !(aw_done_reg || aw_hs) || b_hs;
         wready_reg  <= !(w_done_reg || w_hs) || b_hs;
         if (aw_hs) begin
            aw_done_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (b_hs) begin
            aw_done_reg <= 1'b0;
         end
         if (w_hs) begin
            w_done_reg <= 1'b1;
            wd_reg     <= s_axi_wdata;
            ws_reg     <= s_axi_wstrb;
         end else if (b_hs) begin
            w_done_reg <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? `MBPWM_RESP_OKAY : `MBPWM_RESP_SLVERR;
         end else if (b_hs) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= `MBPWM_RST_WORD;
         rresp_reg   <= `MBPWM_RESP_OKAY;
      end else begin
         arready_reg <= !(rvalid_reg || ar_hs) || r_hs;
         if (ar_hs) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= rd_hit ? `MBPWM_RESP_OKAY : `MBPWM_RESP_SLVERR;
         end else if (r_hs) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register state and write decode
   // ----------------------------------------------------------------
   logic [31:0] status_reg, mask_reg, ctrl_reg, mode_reg, presc_reg;
   logic [31:0] mctrl_reg, cctrl_reg, pwmctl_reg, extctl_reg;
   logic [31:0] tc_reg, pc_reg;
   logic [31:0] shadow_reg [0:6];
   logic [31:0] active_reg [0:6];
   logic [31:0] capt_reg   [0:1];
   logic [6:0]  release_reg;
   logic [1:0]  cap_prev_reg;
   logic [3:0]  ext_reg;
   logic [6:1]  pwm_reg;
   logic        irq_reg;

   wire [31:0] wmask = {{8{ws_reg[3]}}, {8{ws_reg[2]}},
                        {8{ws_reg[1]}}, {8{ws_reg[0]}}};
   wire [31:0] wbits = wd_reg & wmask;
   wire [7:0]  wa    = aw_addr_reg;

   wire we_status  = wr_fire && wa == `MBPWM_OFS_IRQ_STATUS;
   wire we_mask    = wr_fire && wa == `MBPWM_OFS_IRQ_MASK;
   wire we_ctrl    = wr_fire && wa == `MBPWM_OFS_TIMER_CTRL;
   wire we_mode    = wr_fire && wa == `MBPWM_OFS_COUNT_MODE;
   wire we_presc   = wr_fire && wa == `MBPWM_OFS_PRESCALE;
   wire we_mctrl   = wr_fire && wa == `MBPWM_OFS_MATCH_CTRL;
   wire we_release = wr_fire && wa == `MBPWM_OFS_RELEASE;
   wire we_cctrl   = wr_fire && wa == `MBPWM_OFS_CAPT_CTRL;
   wire we_pwmctl  = wr_fire && wa == `MBPWM_OFS_PWM_CTRL;
   wire we_extctl  = wr_fire && wa == `MBPWM_OFS_EXT_CTRL;
   wire wa_match   = wa[7:5] == 3'h1 && wa[4:2] != 3'h7 && wa[1:0] == 2'h0;
   wire wa_plain   = wa == `MBPWM_OFS_IRQ_STATUS
                  || wa == `MBPWM_OFS_IRQ_MASK
                  || wa == `MBPWM_OFS_TIMER_CTRL
                  || wa == `MBPWM_OFS_COUNT_MODE
                  || wa == `MBPWM_OFS_PRESCALE
                  || wa == `MBPWM_OFS_MATCH_CTRL
                  || wa == `MBPWM_OFS_RELEASE
                  || wa == `MBPWM_OFS_CAPT_CTRL
                  || wa == `MBPWM_OFS_PWM_CTRL
                  || wa == `MBPWM_OFS_EXT_CTRL;
   // Count registers are read-only; writes there answer with an error
   assign wr_hit = wa_plain || wa_match;

   // ----------------------------------------------------------------
   // Counting tick and prescaler
   // ----------------------------------------------------------------
   logic [6:0] hit, rst_bits, stop_bits;
   logic [1:0] cap_ev;

   wire             cnt_en   = ctrl_reg[`MBPWM_CTRL_EN_BIT];
   wire             cnt_rst  = ctrl_reg[`MBPWM_CTRL_CRST_BIT];
   wire             pwm_en   = ctrl_reg[`MBPWM_CTRL_PWM_BIT];
   wire             src_sel  = mode_reg[`MBPWM_MODE_SRC_BIT];
   wire mbpwm_cnt_mode_t cmode = mbpwm_cnt_mode_t'(mode_reg[1:0]);
   wire [1:0]       rise     = cap_in & ~cap_prev_reg;
   wire [1:0]       fall     = ~cap_in & cap_prev_reg;
   // RL2 clock source select
   wire src_edge = (cmode == MBPWM_CNT_TIMER)
                || (cmode == MBPWM_CNT_RISE && rise[src_sel])
                || (cmode == MBPWM_CNT_FALL && fall[src_sel])
                || (cmode == MBPWM_CNT_BOTH
                    && (rise[src_sel] || fall[src_sel]));
   wire tick   = cnt_en && !cnt_rst && src_edge;
   // RL16 prescale wrap
   wire tc_adv = tick && pc_reg == presc_reg;
   // RL7 reset on match
   wire tc_clr = |(hit & rst_bits);
   wire period = pwm_en && hit[0];

   // RL1 prescaled counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tc_reg       <= `MBPWM_RST_WORD;
         pc_reg       <= `MBPWM_RST_WORD;
         cap_prev_reg <= 2'h0;
      end else begin
         cap_prev_reg <= cap_in;
         if (cnt_rst) begin
            tc_reg <= `MBPWM_RST_WORD;
            pc_reg <= `MBPWM_RST_WORD;
         end else if (tc_adv) begin
            pc_reg <= `MBPWM_RST_WORD;
            tc_reg <= tc_clr ? `MBPWM_RST_WORD : tc_reg + 32'h1;
         end else if (tick) begin
            pc_reg <= pc_reg + 32'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Match registers
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `MBPWM_NUM_MATCH; gi++) begin : g_match
         localparam int B = gi * `MBPWM_MCTRL_STRIDE;
         wire we_m = wr_fire && wa_match && wa[4:2] == 3'(gi);
         // RL13 exact count compare
         assign hit[gi]       = tc_adv && tc_reg == active_reg[gi];
         assign rst_bits[gi]  = mctrl_reg[B + 1];
         assign stop_bits[gi] = mctrl_reg[B + 2];
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               shadow_reg[gi]  <= `MBPWM_RST_WORD;
               active_reg[gi]  <= `MBPWM_RST_WORD;
               release_reg[gi] <= 1'b0;
            end else begin
               if (we_m) begin
                  shadow_reg[gi] <= (shadow_reg[gi] & ~wmask) | wbits;
               end
               // RL15 direct update, RL17 load at period
               if (!pwm_en || (period && release_reg[gi])) begin
                  active_reg[gi] <= shadow_reg[gi];
               end
               // RL14 release, a new set beats the clear
               release_reg[gi] <= (we_release && wbits[gi])
                                || (release_reg[gi] && !period);
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Capture channels
   // ----------------------------------------------------------------
   generate
      for (gi = 0; gi < `MBPWM_NUM_CAPT; gi++) begin : g_capt
         localparam int B = gi * `MBPWM_CCTRL_STRIDE;
         // RL3 capture on selected edge
         assign cap_ev[gi] = (rise[gi] && cctrl_reg[B])
                          || (fall[gi] && cctrl_reg[B + 1]);
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               capt_reg[gi] <= `MBPWM_RST_WORD;
            end else if (cap_ev[gi]) begin
               capt_reg[gi] <= tc_reg;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Match outputs and pulse outputs
   // ----------------------------------------------------------------
   generate
      for (gi = 0; gi < `MBPWM_NUM_EXT; gi++) begin : g_ext
         wire mbpwm_ext_act_t act = mbpwm_ext_act_t'(extctl_reg[2*gi +: 2]);
         logic nxt;
         // RL5 match output action
         always_comb begin
            unique case (act)
               MBPWM_EXT_KEEP:   nxt = ext_reg[gi];
               MBPWM_EXT_LOW:    nxt = 1'b0;
               MBPWM_EXT_HIGH:   nxt = 1'b1;
               MBPWM_EXT_TOGGLE: nxt = !ext_reg[gi];
            endcase
         end
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               ext_reg[gi] <= 1'b0;
            end else if (hit[gi]) begin
               ext_reg[gi] <= nxt;
            end
         end
      end

      // RL6 outputs one to six over seven matches
      for (gi = 1; gi <= `MBPWM_NUM_PWM; gi++) begin : g_pwm
         // Output one has no spare match before it, so it is single edge only
         wire dbl = (gi > 1) && pwmctl_reg[gi];
         wire oe  = pwmctl_reg[`MBPWM_PWM_OE_BASE + gi];
         // RL9 single rise at period, RL10 double rise at the match before its own
         wire set_ev = dbl ? hit[gi - 1] : hit[0];
         // RL8 fall at own match
         wire clr_ev = hit[gi];
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               pwm_reg[gi] <= 1'b0;
            end else if (!pwm_en || !oe) begin
               pwm_reg[gi] <= 1'b0;
            // RL11 RL12 edges in either order
            end else if (clr_ev) begin
               pwm_reg[gi] <= 1'b0;
            end else if (set_ev) begin
               pwm_reg[gi] <= 1'b1;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Control registers and interrupt
   // ----------------------------------------------------------------
   logic [8:0] irq_ev;
   generate
      for (gi = 0; gi < `MBPWM_NUM_MATCH; gi++) begin : g_mirq
         // RL4 optional match interrupt
         assign irq_ev[`MBPWM_MATCH_IRQ_BASE + gi] =
            hit[gi] && mctrl_reg[gi * `MBPWM_MCTRL_STRIDE];
      end
      for (gi = 0; gi < `MBPWM_NUM_CAPT; gi++) begin : g_cirq
         assign irq_ev[`MBPWM_CAPT_IRQ_BASE + gi] =
            cap_ev[gi] && cctrl_reg[gi * `MBPWM_CCTRL_STRIDE + 2];
      end
   endgenerate

   wire [31:0] clr_bits = we_status ? wbits : `MBPWM_RST_WORD;
   wire [31:0] status_next = (status_reg & ~clr_bits) | {23'h0, irq_ev};
   wire [31:0] ctrl_wr = we_ctrl ? (ctrl_reg & ~wmask) | wbits : ctrl_reg;
   // RL4 stop on match
   wire [31:0] ctrl_next = ctrl_wr & ~{31'h0, |(hit & stop_bits)};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= `MBPWM_RST_WORD;
         mask_reg   <= `MBPWM_RST_WORD;
         ctrl_reg   <= `MBPWM_RST_WORD;
         mode_reg   <= `MBPWM_RST_WORD;
         presc_reg  <= `MBPWM_RST_WORD;
         mctrl_reg  <= `MBPWM_RST_WORD;
         cctrl_reg  <= `MBPWM_RST_WORD;
         pwmctl_reg <= `MBPWM_RST_WORD;
         extctl_reg <= `MBPWM_RST_WORD;
         irq_reg    <= 1'b0;
      end else begin
         status_reg <= status_next;
         ctrl_reg   <= ctrl_next;
         irq_reg    <= |(status_next & mask_reg);
         if (we_mask)   mask_reg   <= (mask_reg & ~wmask) | wbits;
         if (we_mode)   mode_reg   <= (mode_reg & ~wmask) | wbits;
         if (we_presc)  presc_reg  <= (presc_reg & ~wmask) | wbits;
         if (we_mctrl)  mctrl_reg  <= (mctrl_reg & ~wmask) | wbits;
         if (we_cctrl)  cctrl_reg  <= (cctrl_reg & ~wmask) | wbits;
         if (we_pwmctl) pwmctl_reg <= (pwmctl_reg & ~wmask) | wbits;
         if (we_extctl) extctl_reg <= (extctl_reg & ~wmask) | wbits;
      end
   end

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   wire [7:0] ra = s_axi_araddr;
   wire ra_match = ra[7:5] == 3'h1 && ra[4:2] != 3'h7 && ra[1:0] == 2'h0;

   always_comb begin
      rd_hit  = 1'b1;
      rd_word = `MBPWM_RST_WORD;
      if (ra_match) begin
         rd_word = shadow_reg[ra[4:2]];
      end else begin
         unique case (ra)
            `MBPWM_OFS_IRQ_STATUS:  rd_word = status_reg;
            `MBPWM_OFS_IRQ_MASK:    rd_word = mask_reg;
            `MBPWM_OFS_TIMER_CTRL:  rd_word = ctrl_reg;
            `MBPWM_OFS_COUNT_MODE:  rd_word = mode_reg;
            `MBPWM_OFS_TIMER_COUNT: rd_word = tc_reg;
            `MBPWM_OFS_PRESCALE:    rd_word = presc_reg;
            `MBPWM_OFS_PRESC_COUNT: rd_word = pc_reg;
            `MBPWM_OFS_MATCH_CTRL:  rd_word = mctrl_reg;
            `MBPWM_OFS_RELEASE:     rd_word = {25'h0, release_reg};
            `MBPWM_OFS_CAPT_CTRL:   rd_word = cctrl_reg;
            `MBPWM_OFS_CAPTURE0:    rd_word = capt_reg[0];
            `MBPWM_OFS_CAPTURE1:    rd_word = capt_reg[1];
            `MBPWM_OFS_PWM_CTRL:    rd_word = pwmctl_reg;
            `MBPWM_OFS_EXT_CTRL:    rd_word = extctl_reg;
            default:                rd_hit  = 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Output drive
   // ----------------------------------------------------------------
   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
   assign match_out     = ext_reg;
   assign pwm_out       = pwm_reg;
   assign irq           = irq_reg;

endmodule : mbpwm_top
`default_nettype wire

// ### tb/mbpwm_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module mbpwm_top_asserts (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   import mbpwm_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // --------------------
   // Bus handshakes
   // --------------------
   AST_AW_ONCE: assert property (s_axi_awvalid && s_axi_awready |=>
      !s_axi_awready) else $error("aw ready high after take");
   AST_W_ONCE: assert property (s_axi_wvalid && s_axi_wready |=>
      !s_axi_wready) else $error("w ready high after take");
   AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid) else $error("write response dropped");
   AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write response not retired");
   AST_AR_RESP: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("read answer late");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid && s_axi_arready) else $error("read not retired");
endmodule : mbpwm_top_asserts

bind mbpwm_top mbpwm_top_asserts mbpwm_top_asserts_i (
   .clk(clk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ### tb/mbpwm_pins.sv
`timescale 1ns/1ns
`default_nettype none
module mbpwm_pins (
   input  wire logic [1:0] req,
   input  wire logic       clk,
   output logic      [1:0] cap_in
);
   logic [1:0] c0 = 2'h0;
   logic [1:0] c1 = 2'h0;
   // --------------------
   // Pin pulses
   // --------------------
   // Two high, two low: every edge is a fresh sample
   always @(posedge clk) begin
      c0 <= (c0 != 2'h0) ? c0 - 2'h1 : {req[0], req[0]};
      c1 <= (c1 != 2'h0) ? c1 - 2'h1 : {req[1], req[1]};
   end
   assign cap_in = {c1[1], c0[1]};
endmodule : mbpwm_pins
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import mbpwm_pkg::*;
   logic        clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   mbpwm_resp_t bresp, rresp;
   logic [1:0]  req, cap_in;
   logic [3:0]  match_out;
   logic [6:1]  pwm_out;
   int          fail_count = 0;
   int          checked = 0;
   int          cyc = 0;

   mbpwm_top mbpwm_top_i (
      .clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .cap_in(cap_in), .match_out(match_out),
      .pwm_out(pwm_out), .irq(irq));
   mbpwm_pins mbpwm_pins_i (.req(req), .clk(clk), .cap_in(cap_in));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic summarize();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] want);
      checked++;
      if (got !== want) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask : cmp

   // --------------------
   // Bus access
   // --------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = 2'h0);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge clk);
         ad |= awready;
         wd |= wready;
         if (ad) awvalid <= 1'b0;
         if (wd) wvalid <= 1'b0;
      end
      do @(posedge clk); while (!bvalid);
      bready <= 1'b1;
      @(posedge clk);
      bready <= 1'b0;
      cmp(bresp, er);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] want,
                     input logic [1:0] er = 2'h0);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rready <= 1'b1;
      @(posedge clk);
      rready <= 1'b0;
      cmp(rdata, want);
      cmp(rresp, er);
   endtask : rd

   task automatic hi(input int n, input logic [31:0] want);
      logic [31:0] c;
      c = 32'h0;
      repeat (40) begin
         @(posedge clk);
         c = c + pwm_out[n];
      end
      cmp(c, want);
   endtask : hi

   task automatic pulse(input int c);
      req[c] <= 1'b1;
      @(posedge clk);
      req[c] <= 1'b0;
      repeat (5) @(posedge clk);
   endtask : pulse

   initial begin
      arst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, req} = '0;
      {awaddr, araddr, wdata} = '0;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rd(8'h00, 32'h0);
      rd(8'h5C, 32'h0, 2'h2);
      wr(8'h10, 32'h5, 2'h2);
      wr(8'h14, 32'h1);
      wr(8'h20, 32'h9);
      wr(8'h24, 32'h4);
      wr(8'h1C, 32'h3);
      wr(8'h4C, 32'h200);
      wr(8'h3C, 32'h3);
      wr(8'h08, 32'h9);
      repeat (60) @(posedge clk);
      hi(1, 32'h14); // five of ten counts high
      wr(8'h24, 32'h7);
      repeat (40) @(posedge clk);
      hi(1, 32'h14); // old width kept
      wr(8'h3C, 32'h2);
      repeat (60) @(posedge clk);
      hi(1, 32'h20); // new width applied
      rd(8'h3C, 32'h0); // release bits cleared
      wr(8'h28, 32'h2);
      wr(8'h4C, 32'h604);
      wr(8'h3C, 32'h4);
      repeat (60) @(posedge clk);
      hi(2, 32'h14); // negative pulse width
      rd(8'h00, 32'h1); // match event flagged
      cmp(irq, 32'h0);
      wr(8'h08, 32'h0);
      wr(8'h1C, 32'h0);
      wr(8'h00, 32'h1FF);
      repeat (3) @(posedge clk);
      cmp(pwm_out, 32'h0); // outputs idle
      rd(8'h00, 32'h0);
      wr(8'h08, 32'h2);
      wr(8'h14, 32'h0);
      wr(8'h20, 32'h1);
      wr(8'h24, 32'h2);
      wr(8'h50, 32'h1B);
      wr(8'h40, 32'h28);
      wr(8'h0C, 32'h1);
      wr(8'h04, 32'h100);
      wr(8'h08, 32'h1);
      repeat (3) pulse(0);
      rd(8'h10, 32'h3); // edges counted
      cmp(match_out, 32'h3); // toggle and set
      pulse(1);
      cmp(irq, 32'h1); // capture interrupt
      rd(8'h48, 32'h3); // count snapshot
      rd(8'h00, 32'h100);
      wr(8'h00, 32'h100);
      repeat (3) @(posedge clk);
      cmp(irq, 32'h0);
      wr(8'h0C, 32'h2);
      wr(8'h30, 32'h5);
      wr(8'h1C, 32'h4000);
      repeat (4) pulse(0);
      rd(8'h10, 32'h6); // falling edges stop at match
      rd(8'h08, 32'h0); // stop clears enable
      summarize();
   end
endmodule : tb_top
`default_nettype wire
